// File: common/pmt_cfg.svh
// constants of the three-channel period-match timer block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
//
// Function
// [RULE1] counting stops completely while the processor sleeps
// [RULE2] count and period hold their values during sleep
// [RULE3] postscale field value plus one sets matches per flag
// [RULE4] each timer has an 8-bit count readable and writable by software
// [RULE5] each timer has its own writable period compared with the count
// [RULE6] count advances only while the run bit (control bit 2) is set
// [RULE7] prescale codes 00, 01, 10, 11 divide input by 1, 4, 16, 64
// [RULE8] count equal to period gives a match pulse and count restarts at zero
// [RULE9] count or control writes and resets clear both scaler counters
// [RULE10] postscaler sets a sticky flag, requesting interrupt only when enabled
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// register map, byte addresses
`define PMT_OFS_CTRL    8'h00
`define PMT_OFS_PERIOD  8'h04
`define PMT_OFS_COUNT   8'h08
`define PMT_STRIDE      8'h0C
`define PMT_OFS_FLAG    8'h24
`define PMT_OFS_ENABLE  8'h28

// control register fields
`define PMT_OUTPS_LSB   3
`define PMT_RUN_BIT     2
`define PMT_CKPS_LSB    0
`define PMT_CTRL_MASK   8'h7F

// reset values
`define PMT_CTRL_RST    8'h00
`define PMT_PERIOD_RST  8'hFF
`define PMT_COUNT_RST   8'h00

// prescaler terminal counts
`define PMT_PS_LIM1     6'h00
`define PMT_PS_LIM4     6'h03
`define PMT_PS_LIM16    6'h0F
`define PMT_PS_LIM64    6'h3F

// bus responses
`define PMT_RESP_OKAY   2'b00
`define PMT_RESP_SLVERR 2'b10

`endif

// File: common/pmt_pkg.sv
// types shared by the period-match timer block
// assumes pmt_cfg.svh is compiled alongside
package pmt_pkg;

  // clock prescale selection
  typedef enum logic [1:0] {
    PMT_PS_DIV1  = 2'b00,
    PMT_PS_DIV4  = 2'b01,
    PMT_PS_DIV16 = 2'b10,
    PMT_PS_DIV64 = 2'b11
  } pmt_prescale_t;

  // register kind selected by an address
  typedef enum logic [2:0] {
    PMT_SEL_CTRL   = 3'h0,
    PMT_SEL_PERIOD = 3'h1,
    PMT_SEL_COUNT  = 3'h2,
    PMT_SEL_FLAG   = 3'h3,
    PMT_SEL_ENABLE = 3'h4,
    PMT_SEL_NONE   = 3'h7
  } pmt_sel_t;

  // result of an address decode
  typedef struct packed {
    logic       hit;
    pmt_sel_t   sel;
    logic [1:0] idx;
  } pmt_dec_t;

endpackage

// File: logic/pmt_sync.sv
// three-stage synchroniser with agreement filter for one level
// assumes the input is asynchronous to core_clk_i
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_sync (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      level_o
);
  import pmt_pkg::*;

  logic stage1;
  logic stage2;
  logic stage3;

  // shift chain, first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      level_o <= 1'b0;
    end else if (stage2 == stage3) begin
      level_o <= stage3;
    end
  end

endmodule // pmt_sync

// File: logic/pmt_timer.sv
// one 8-bit period-match timer with prescaler and postscaler
// assumes control and period are held by the register file
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_timer (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  halt_i,
  input  wire logic                  run_i,
  input  wire pmt_pkg::pmt_prescale_t ckps_i,
  input  wire logic [3:0]            outps_i,
  input  wire logic [7:0]            period_i,
  input  wire logic                  cnt_wr_i,
  input  wire logic                  ctl_wr_i,
  input  wire logic [7:0]            wdata_i,
  output logic [7:0]                 count_o,
  output logic                       match_o,
  output logic                       post_o
);
  import pmt_pkg::*;

  logic [5:0] pre_cnt;
  logic [3:0] post_cnt;
  logic       advance;
  logic       tick;
  logic       hit;
  logic       scaler_clr;

  // terminal count of the prescaler for a code
  function automatic logic [5:0] prescale_limit(input pmt_prescale_t ps);
    case (ps)
      PMT_PS_DIV1:  prescale_limit = `PMT_PS_LIM1;
      PMT_PS_DIV4:  prescale_limit = `PMT_PS_LIM4;
      PMT_PS_DIV16: prescale_limit = `PMT_PS_LIM16;
      default:      prescale_limit = `PMT_PS_LIM64;
    endcase
  endfunction

  // run gating and sleep freeze
  assign advance    = run_i && !halt_i;        // [RULE1] [RULE6]
  assign tick       = advance && (pre_cnt == prescale_limit(ckps_i)); // [RULE7]
  assign hit        = tick && !cnt_wr_i && (count_o == period_i); // [RULE8]
  assign scaler_clr = cnt_wr_i || ctl_wr_i;    // [RULE9]

  // prescaler counter
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pre_cnt <= 6'h00;                        // [RULE9]
    end else if (scaler_clr) begin
      pre_cnt <= 6'h00;                        // [RULE9]
    end else if (tick) begin
      pre_cnt <= 6'h00;
    end else if (advance) begin
      pre_cnt <= pre_cnt + 6'h01;              // [RULE7]
    end
  end

  // count register, held whenever neither advancing nor written
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      count_o <= `PMT_COUNT_RST;
    end else if (cnt_wr_i) begin
      count_o <= wdata_i;                      // [RULE4]
    end else if (hit) begin
      count_o <= 8'h00;                        // [RULE8]
    end else if (tick) begin
      count_o <= count_o + 8'h01;              // [RULE2]
    end
  end

  // unscaled match pulse
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      match_o <= 1'b0;
    end else begin
      match_o <= hit;                          // [RULE8]
    end
  end

  // postscaler, one event per outps+1 matches
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      post_cnt <= 4'h0;
      post_o   <= 1'b0;
    end else if (scaler_clr) begin
      post_cnt <= 4'h0;                        // [RULE9]
      post_o   <= 1'b0;
    end else if (hit) begin
      post_o   <= (post_cnt == outps_i);       // [RULE3]
      post_cnt <= (post_cnt == outps_i) ? 4'h0 : post_cnt + 4'h1;
    end else begin
      post_o   <= 1'b0;
    end
  end

endmodule // pmt_timer

// File: logic/pmt_top.sv
// three period-match timers behind an AXI4-Lite register slave
// assumes sleep_i comes from the processor core, asynchronous here
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // processor sleep state
  input  wire logic              sleep_i,
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  // write data channel
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // write response channel
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  // read data channel
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // timer outputs
  output logic [2:0]             match_o,
  output logic [2:0]             irq_o
);
  import pmt_pkg::*;

  localparam int NUM_TMR = 3;

  // register file
  logic [7:0]        ctrl   [NUM_TMR];
  logic [7:0]        period [NUM_TMR];
  logic [7:0]        count  [NUM_TMR];
  logic [2:0]        flag;
  logic [2:0]        enable;

  // per-timer strobes and events
  logic [2:0]        post_evt;
  logic [2:0]        cnt_wr;
  logic [2:0]        ctl_wr;
  logic [2:0]        flag_clr;

  // synchronised sleep level
  logic              sleeping;

  // write channel state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              wr_lane0;

  // address decode and read data
  pmt_dec_t          wr_dec;
  pmt_dec_t          rd_dec;
  logic [31:0]       next_rdata;

  // map a byte address onto a register kind and timer index
  function automatic pmt_dec_t addr_decode(input logic [ADDR_W-1:0] a);
    pmt_dec_t d;
    logic [7:0] a8;
    d  = '{hit: 1'b0, sel: PMT_SEL_NONE, idx: 2'd0};
    a8 = 8'(a);
    if (a8 == `PMT_OFS_FLAG) begin
      d = '{hit: 1'b1, sel: PMT_SEL_FLAG, idx: 2'd0};
    end else if (a8 == `PMT_OFS_ENABLE) begin
      d = '{hit: 1'b1, sel: PMT_SEL_ENABLE, idx: 2'd0};
    end else if (a8 == `PMT_OFS_CTRL) begin
      d = '{hit: 1'b1, sel: PMT_SEL_CTRL, idx: 2'd0};
    end else if (a8 == `PMT_OFS_PERIOD) begin
      d = '{hit: 1'b1, sel: PMT_SEL_PERIOD, idx: 2'd0};
    end else if (a8 == `PMT_OFS_COUNT) begin
      d = '{hit: 1'b1, sel: PMT_SEL_COUNT, idx: 2'd0};
    end else if (a8 == `PMT_STRIDE + `PMT_OFS_CTRL) begin
      d = '{hit: 1'b1, sel: PMT_SEL_CTRL, idx: 2'd1};
    end else if (a8 == `PMT_STRIDE + `PMT_OFS_PERIOD) begin
      d = '{hit: 1'b1, sel: PMT_SEL_PERIOD, idx: 2'd1};
    end else if (a8 == `PMT_STRIDE + `PMT_OFS_COUNT) begin
      d = '{hit: 1'b1, sel: PMT_SEL_COUNT, idx: 2'd1};
    end else if (a8 == `PMT_STRIDE + `PMT_STRIDE + `PMT_OFS_CTRL) begin
      d = '{hit: 1'b1, sel: PMT_SEL_CTRL, idx: 2'd2};
    end else if (a8 == `PMT_STRIDE + `PMT_STRIDE + `PMT_OFS_PERIOD) begin
      d = '{hit: 1'b1, sel: PMT_SEL_PERIOD, idx: 2'd2};
    end else if (a8 == `PMT_STRIDE + `PMT_STRIDE + `PMT_OFS_COUNT) begin
      d = '{hit: 1'b1, sel: PMT_SEL_COUNT, idx: 2'd2};
    end
    if (ADDR_W > 8 && (a >> 8) != '0) begin
      d = '{hit: 1'b0, sel: PMT_SEL_NONE, idx: 2'd0};
    end
    return d;
  endfunction

  // processor sleep level brought into the clock domain
  pmt_sync u_sleep_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (sleep_i),
    .level_o    (sleeping)
  );

  // write channel readiness: one write in flight at a time
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign wr_go    = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_dec   = addr_decode(aw_addr);
  assign wr_lane0 = wr_go && wr_dec.hit && w_strb[0];

  // capture write address and data in either order
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // write data and strobes, kept until the register is written
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid_o <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // response code, refused for unmapped places, held until taken
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_bresp_o <= `PMT_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bresp_o <= wr_dec.hit ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
    end
  end

  // per-timer write strobes into the counters
  always_comb begin
    cnt_wr   = 3'b000;
    ctl_wr   = 3'b000;
    flag_clr = 3'b000;
    if (wr_lane0) begin
      if (wr_dec.sel == PMT_SEL_COUNT) begin
        cnt_wr[wr_dec.idx] = 1'b1;             // [RULE9]
      end else if (wr_dec.sel == PMT_SEL_CTRL) begin
        ctl_wr[wr_dec.idx] = 1'b1;             // [RULE9]
      end else if (wr_dec.sel == PMT_SEL_FLAG) begin
        flag_clr = w_data[2:0];
      end
    end
  end

  // control registers; bit 7 is not implemented
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        ctrl[i] <= `PMT_CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_TMR; i++) begin
        if (ctl_wr[i]) begin
          ctrl[i] <= w_data[7:0] & `PMT_CTRL_MASK;
        end
      end
    end
  end

  // period registers, held across sleep
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        period[i] <= `PMT_PERIOD_RST;
      end
    end else if (wr_lane0 && wr_dec.sel == PMT_SEL_PERIOD) begin
      period[wr_dec.idx] <= w_data[7:0];       // [RULE5] [RULE2]
    end
  end

  // the three timer channels
  for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
    pmt_timer u_tmr (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .halt_i     (sleeping),                  // [RULE1]
      .run_i      (ctrl[g][`PMT_RUN_BIT]),     // [RULE6]
      .ckps_i     (pmt_prescale_t'(ctrl[g][`PMT_CKPS_LSB +: 2])),
      .outps_i    (ctrl[g][`PMT_OUTPS_LSB +: 4]), // [RULE3]
      .period_i   (period[g]),                 // [RULE5]
      .cnt_wr_i   (cnt_wr[g]),
      .ctl_wr_i   (ctl_wr[g]),
      .wdata_i    (w_data[7:0]),
      .count_o    (count[g]),                  // [RULE4]
      .match_o    (match_o[g]),
      .post_o     (post_evt[g])
    );
  end

  // sticky match flags; a new event beats a clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      flag <= 3'b000;
    end else begin
      flag <= post_evt | (flag & ~flag_clr);   // [RULE10]
    end
  end

  // interrupt enable bits
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      enable <= 3'b000;
    end else if (wr_lane0 && wr_dec.sel == PMT_SEL_ENABLE) begin
      enable <= w_data[2:0];
    end
  end

  // interrupt requests gated by the enables
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 3'b000;
    end else begin
      irq_o <= flag & enable;                  // [RULE10]
    end
  end

  // read data mux
  assign rd_dec = addr_decode(s_axi_araddr_i);
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_dec.sel == PMT_SEL_CTRL) begin
      next_rdata[7:0] = ctrl[rd_dec.idx];
    end else if (rd_dec.sel == PMT_SEL_PERIOD) begin
      next_rdata[7:0] = period[rd_dec.idx];
    end else if (rd_dec.sel == PMT_SEL_COUNT) begin
      next_rdata[7:0] = count[rd_dec.idx];     // [RULE4]
    end else if (rd_dec.sel == PMT_SEL_FLAG) begin
      next_rdata[2:0] = flag;
    end else if (rd_dec.sel == PMT_SEL_ENABLE) begin
      next_rdata[2:0] = enable;
    end
  end

  // read channel, one read in flight at a time
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // read data and code, captured once and held while stalled
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `PMT_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= rd_dec.hit ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
    end
  end

endmodule // pmt_top

// File: dv/pmt_top_assertions.sv
// port-level checks for the three-channel period-match timer
// assumes it is bound to pmt_top, one clock, synchronous reset
`timescale 1ns/1ps
module pmt_top_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              sleep_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire logic [2:0]        match_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // cycles spent asleep, saturating
  logic [3:0] sleep_cnt;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !sleep_i) begin
      sleep_cnt <= 4'h0;
    end else if (sleep_cnt != 4'hF) begin
      sleep_cnt <= sleep_cnt + 4'h1;
    end
  end

  // bus transfers taken
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  // both halves held at the taking edge, register written one edge later
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid_o)
    else $error("write not answered in time");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
    else $error("read not answered next cycle");
  a_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data changed while stalled");
  a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address accepted while busy");
  a_write_busy: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  a_upper_zero: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_read: assert property (s_rd_taken and
    s_axi_araddr_i > 8'h28 |=> s_axi_rresp_o == 2'b10 &&
    s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_sleep_quiet: assert property (sleep_cnt > 4'h6 |-> match_o == 3'h0)
    else $error("match while asleep");
endmodule // pmt_top_assertions

bind pmt_top pmt_top_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i, .sys_rst_i, .sleep_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .match_o
);

// File: dv/period_match_timer8_test.sv
// self-checking bench for the period-match timer block
// assumes pmt_top with its AXI4-Lite slave, 50 MHz clock
`timescale 1ns/1ps
module period_match_timer8_test;
  logic        core_clk_i, sys_rst_i, sleep_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [2:0]  s_axi_awprot_i, s_axi_arprot_i, match_o, irq_o;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic        s_axi_rready_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rdv;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
  int          bad_count, compares;

  pmt_top dut (
    .core_clk_i, .sys_rst_i, .sleep_i, .s_axi_awaddr_i, .s_axi_awprot_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .match_o, .irq_o
  );

  // clock, 20 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: resp %b want %b", $time, got, exp);
    end
  endtask

  // bus write; response accepted one cycle late to show it holds
  task automatic wr(input int a, input int d);
    @(posedge core_clk_i);
    s_axi_awaddr_i <= 8'(a);
    s_axi_wdata_i <= 32'(d);
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b1;
    @(posedge core_clk_i);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  // bus read; data accepted one cycle late
  task automatic rd(input int a);
    @(posedge core_clk_i);
    s_axi_araddr_i <= 8'(a);
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b1;
    @(posedge core_clk_i);
    rdv = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  // reset values, read-back, unused bit, unmapped place
  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(12 * i);
      check_val(rdv, 8'h00);
      rd(12 * i + 4);
      check_val(rdv, 8'hFF);
      rd(12 * i + 8);
      check_val(rdv, 8'h00);
      wr(12 * i + 4, 8'h5A + i);
      rd(12 * i + 4);
      check_val(rdv, 8'h5A + i);
      wr(12 * i + 8, 8'hA5 - i);
      rd(12 * i + 8);
      check_val(rdv, 8'hA5 - i);
    end
    wr(0, 8'hFF);
    rd(0);
    check_val(rdv, 8'h7F);
    wr(0, 0);
    wr(8'h2C, 1);
    check_resp(rsp, 2'b10);
    rd(8'h2C);
    check_resp(rsp, 2'b10);
  endtask

  // match spacing for every prescale code, all three timers
  task automatic t_prescale;
    int t, n;
    for (int c = 0; c < 4; c++) begin
      t = c % 3;
      n = 0;
      wr(12 * t + 4, 3);
      wr(12 * t + 8, 0);
      wr(12 * t, 4 + c);
      do @(posedge core_clk_i); while (!match_o[t]);
      do begin
        @(posedge core_clk_i);
        n++;
      end while (!match_o[t]);
      check_val(n, 4 << (2 * c));
      wr(12 * t, 0);
    end
  endtask

  // matches per flag for each postscale code, then masked flag
  task automatic t_post;
    int m;
    wr(8'h28, 1);
    wr(4, 3);
    for (int k = 0; k < 16; k++) begin
      wr(0, 0);
      wr(8'h24, 1);
      wr(8, 0);
      wr(0, (k << 3) | 4);
      m = 0;
      while (!irq_o[0]) begin
        @(posedge core_clk_i);
        if (match_o[0]) m++;
      end
      check_val(m, k + 1);
    end
    wr(8'h28, 0);
    wr(0, 0);
    wr(8'h24, 1);
    wr(0, 4);
    repeat (20) @(posedge core_clk_i);
    check_val(irq_o, 0);
    rd(8'h24);
    check_val(rdv & 1, 1);
    wr(0, 0);
  endtask

  // run bit off and sleep both freeze the count
  task automatic t_sleep;
    logic [31:0] a;
    wr(4, 8'hFF);
    wr(8, 8'h10);
    repeat (20) @(posedge core_clk_i);
    rd(8);
    check_val(rdv, 8'h10);
    wr(0, 4);
    sleep_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    rd(8);
    a = rdv;
    repeat (30) @(posedge core_clk_i);
    rd(8);
    check_val(rdv, a);
    rd(4);
    check_val(rdv, 8'hFF);
    sleep_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    rd(8);
    check_val(rdv > a, 1);
  endtask

  // control or count write restarts the prescaler; count kept
  task automatic t_clear;
    int n;
    wr(0, 0);
    wr(4, 0);
    wr(8, 0);
    for (int j = 0; j < 2; j++) begin
      wr(0, 7);
      repeat (37) @(posedge core_clk_i);
      wr(j ? 8 : 0, j ? 0 : 7);
      n = 0;
      while (!match_o[0]) begin
        @(posedge core_clk_i);
        n++;
      end
      check_val(n >= 58 && n <= 68, 1);
    end
    wr(8, 8'h55);
    wr(0, 0);
    rd(8);
    check_val(rdv, 8'h55);
  endtask

  // hang guard
  initial begin
    repeat (30000) @(posedge core_clk_i);
    bad_count++;
    complete_run();
  end

  // reset, then scenarios
  initial begin
    {sleep_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_awprot_i} = '0;
    s_axi_arprot_i = 3'h0;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'hF;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_prescale();
    t_post();
    t_sleep();
    t_clear();
    complete_run();
  end
endmodule // period_match_timer8_test
